// file: rtl/spmc_top.sv
// Scan pin mode control: TAP, pin ownership, pull-ups and probe routing.
// Assumes AXI4-Lite master on i_clk_sys; test pins and fuse are asynchronous.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
module spmc_top #(
  parameter int unsigned NET_CNT = 16
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_b,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [31:0]          s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  input  wire logic                 i_tms,
  input  wire spmc_pkg::spmc_pins_t i_pin_in,
  output spmc_pkg::spmc_pins_t      o_pin_out,
  output spmc_pkg::spmc_pins_t      o_pin_oe,
  input  wire spmc_pkg::spmc_pins_t i_user_out,
  input  wire spmc_pkg::spmc_pins_t i_user_oe,
  output spmc_pkg::spmc_pins_t      o_user_in,
  output logic                      o_pu_tms,
  output logic                      o_pu_tdi,
  output logic                      o_pu_trst,
  input  wire logic                 i_sec_fuse,
  input  wire logic [NET_CNT-1:0]   i_nets,
  output logic                      o_probe_out_a,
  output logic                      o_probe_out_b
);
  logic                 rst_s1_ff, rst_n_ff;
  logic [4:0]           pad_s1_ff, pad_s2_ff;
  logic                 tck_d_ff;
  logic                 tck_s, tms_s, tdi_s, trst_s, fuse_s, tck_rise, tck_fall;
  logic [31:0]          ctrl_ff;
  logic                 ded, trst_rsv, claim, tap_rst;
  logic                 owned_ff, scan_act;
  spmc_pkg::spmc_tap_t  tap_ff;
  logic [3:0]           ir_ff, ir_sh_ff;
  spmc_pkg::spmc_sel_t  sel_ff, dr_sh_ff;
  logic                 byp_ff, tdo_ff, tdo_en_ff;
  logic [2:0]           tms_hi_ff;
  logic                 aw_full_ff, w_full_ff, nxt_aw_full, nxt_w_full, wr_go;
  logic [31:0]          awaddr_ff, wdata_ff;
  logic [3:0]           wstrb_ff;
  logic [31:0]          status;

  // Release reset through two flops so no flop leaves reset on a ragged edge
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pad_s1_ff <= 5'h0;
      pad_s2_ff <= 5'h0;
      tck_d_ff  <= 1'b0;
    end else begin
      pad_s1_ff <= {i_sec_fuse, i_pin_in.trst, i_pin_in.tdi, i_tms, i_pin_in.tck};
      pad_s2_ff <= pad_s1_ff;
      tck_d_ff  <= pad_s2_ff[0];
    end
  end

  assign {fuse_s, trst_s, tdi_s, tms_s, tck_s} = pad_s2_ff;
  assign tck_rise = tck_s & ~tck_d_ff;
  assign tck_fall = ~tck_s & tck_d_ff;
  assign ded      = ctrl_ff[spmc_pkg::CTRL_DED];
  assign trst_rsv = ctrl_ff[spmc_pkg::CTRL_TRST];
  // TRST needs no TCK edge; it holds the TAP while low
  assign tap_rst  = trst_rsv & ~trst_s;                          // [RULE8]
  assign claim    = tck_rise & ~tms_s & ~ded;                    // [RULE5]
  assign scan_act = ded | owned_ff;                              // [RULE2]

  function automatic spmc_pkg::spmc_tap_t tap_next(spmc_pkg::spmc_tap_t s, logic m);
    unique case (s)
      spmc_pkg::S_TLR:  tap_next = m ? spmc_pkg::S_TLR  : spmc_pkg::S_RTI;
      spmc_pkg::S_RTI:  tap_next = m ? spmc_pkg::S_SDS  : spmc_pkg::S_RTI;
      spmc_pkg::S_SDS:  tap_next = m ? spmc_pkg::S_SIS  : spmc_pkg::S_CDR;
      spmc_pkg::S_CDR:  tap_next = m ? spmc_pkg::S_E1DR : spmc_pkg::S_SHDR;
      spmc_pkg::S_SHDR: tap_next = m ? spmc_pkg::S_E1DR : spmc_pkg::S_SHDR;
      spmc_pkg::S_E1DR: tap_next = m ? spmc_pkg::S_UDR  : spmc_pkg::S_PDR;
      spmc_pkg::S_PDR:  tap_next = m ? spmc_pkg::S_E2DR : spmc_pkg::S_PDR;
      spmc_pkg::S_E2DR: tap_next = m ? spmc_pkg::S_UDR  : spmc_pkg::S_SHDR;
      spmc_pkg::S_UDR:  tap_next = m ? spmc_pkg::S_SDS  : spmc_pkg::S_RTI;
      spmc_pkg::S_SIS:  tap_next = m ? spmc_pkg::S_TLR  : spmc_pkg::S_CIR;
      spmc_pkg::S_CIR:  tap_next = m ? spmc_pkg::S_E1IR : spmc_pkg::S_SHIR;
      spmc_pkg::S_SHIR: tap_next = m ? spmc_pkg::S_E1IR : spmc_pkg::S_SHIR;
      spmc_pkg::S_E1IR: tap_next = m ? spmc_pkg::S_UIR  : spmc_pkg::S_PIR;
      spmc_pkg::S_PIR:  tap_next = m ? spmc_pkg::S_E2IR : spmc_pkg::S_PIR;
      spmc_pkg::S_E2IR: tap_next = m ? spmc_pkg::S_UIR  : spmc_pkg::S_SHIR;
      spmc_pkg::S_UIR:  tap_next = m ? spmc_pkg::S_SDS  : spmc_pkg::S_RTI;
      default:          tap_next = spmc_pkg::S_TLR;
    endcase
  endfunction

  // TAP follows TMS on TCK rising edges; TMS is also read by the claim and the TMS-high counter
  always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tap_ff <= spmc_pkg::S_TLR;                                 // [RULE13]
    end else if (tap_rst) begin
      tap_ff <= spmc_pkg::S_TLR;                                 // [RULE8]
    end else if (tck_rise) begin
      tap_ff <= tap_next(tap_ff, tms_s);                         // [RULE1] [RULE3] [RULE7] [RULE13]
    end
  end

  // Ownership: a claim in the same cycle as the release wins
  always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      owned_ff <= 1'b0;
    end else if (claim) begin
      owned_ff <= 1'b1;                                          // [RULE5]
    end else if (tap_ff == spmc_pkg::S_TLR) begin
      owned_ff <= 1'b0;                                          // [RULE6]
    end
  end

  // Instruction and data shift paths; probe selects live in one data register
  always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ir_ff    <= spmc_pkg::IR_BYPASS;
      ir_sh_ff <= spmc_pkg::IR_CAPTURE;
      dr_sh_ff <= '0;
      sel_ff   <= '0;
      byp_ff   <= 1'b0;
    end else if (tap_rst) begin
      ir_ff    <= spmc_pkg::IR_BYPASS;
      sel_ff   <= '0;
    end else if (tck_rise) begin
      unique case (tap_ff)
        spmc_pkg::S_TLR:  ir_ff <= spmc_pkg::IR_BYPASS;
        spmc_pkg::S_CIR:  ir_sh_ff <= spmc_pkg::IR_CAPTURE;
        spmc_pkg::S_SHIR: ir_sh_ff <= {tdi_s, ir_sh_ff[spmc_pkg::IR_W-1:1]};
        spmc_pkg::S_UIR:  ir_ff <= ir_sh_ff;
        spmc_pkg::S_CDR: begin
          dr_sh_ff <= sel_ff;
          byp_ff   <= 1'b0;
        end
        spmc_pkg::S_SHDR: begin
          dr_sh_ff <= {tdi_s, dr_sh_ff[2*spmc_pkg::SEL_W-1:1]};
          byp_ff   <= tdi_s;
        end
        spmc_pkg::S_UDR: begin
          if (ir_ff == spmc_pkg::IR_PROBE) begin
            sel_ff <= dr_sh_ff;                                  // [RULE10]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // TDO changes on the falling TCK edge so the tester samples a stable bit
  always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tdo_ff    <= 1'b0;
      tdo_en_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_en_ff <= (tap_ff == spmc_pkg::S_SHIR) | (tap_ff == spmc_pkg::S_SHDR);
      if (tap_ff == spmc_pkg::S_SHIR) begin
        tdo_ff <= ir_sh_ff[0];
      end else if (ir_ff == spmc_pkg::IR_PROBE) begin
        tdo_ff <= dr_sh_ff[0];
      end else begin
        tdo_ff <= byp_ff;
      end
    end
  end

  // Counts TCK rises with TMS high; read by the checks only
  always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tms_hi_ff <= 3'h0;
    end else if (tck_rise) begin
      tms_hi_ff <= !tms_s ? 3'h0 : (tms_hi_ff == 3'h7) ? tms_hi_ff : tms_hi_ff + 3'h1;
    end
  end

  // Pin muxing, pull-ups and probes, all registered
  always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_pin_out     <= '0;
      o_pin_oe      <= '0;
      o_user_in     <= '0;
      o_pu_tms      <= 1'b0;
      o_pu_tdi      <= 1'b0;
      o_pu_trst     <= 1'b0;
      o_probe_out_a <= 1'b0;
      o_probe_out_b <= 1'b0;
    end else begin
      o_pu_tms  <= ded;                                          // [RULE3] [RULE4]
      o_pu_tdi  <= ded;                                          // [RULE3] [RULE4]
      o_pu_trst <= trst_rsv;                                     // [RULE8] [RULE9]
      // User side sees synchronised TCK, TDI and TRST pads; TDO and a scan-owned pin read as zero
      o_user_in.tck  <= scan_act ? 1'b0 : tck_s;                 // [RULE2] [RULE4]
      o_user_in.tdi  <= scan_act ? 1'b0 : tdi_s;
      o_user_in.tdo  <= 1'b0;
      o_user_in.trst <= trst_rsv ? 1'b0 : trst_s;                // [RULE9]
      o_pin_out.tck  <= scan_act ? 1'b0 : i_user_out.tck;
      o_pin_oe.tck   <= scan_act ? 1'b0 : i_user_oe.tck;         // [RULE2] [RULE6]
      o_pin_out.tdi  <= scan_act ? 1'b0 : i_user_out.tdi;
      o_pin_oe.tdi   <= scan_act ? 1'b0 : i_user_oe.tdi;
      o_pin_out.tdo  <= scan_act ? tdo_ff : i_user_out.tdo;
      o_pin_oe.tdo   <= scan_act ? tdo_en_ff : i_user_oe.tdo;
      o_pin_out.trst <= trst_rsv ? 1'b0 : i_user_out.trst;
      o_pin_oe.trst  <= trst_rsv ? 1'b0 : i_user_oe.trst;        // [RULE8] [RULE9]
      // Out-of-range selects give zero rather than a wrapped net
      o_probe_out_a <= !fuse_s && (sel_ff.a < NET_CNT) && i_nets[sel_ff.a]; // [RULE10] [RULE11]
      o_probe_out_b <= !fuse_s && (sel_ff.b < NET_CNT) && i_nets[sel_ff.b]; // [RULE10] [RULE11]
    end
  end

  // AXI4-Lite write: address and data taken in either order
  always_comb begin
    nxt_aw_full = aw_full_ff | (s_axi_awvalid & s_axi_awready);
    nxt_w_full  = w_full_ff | (s_axi_wvalid & s_axi_wready);
    wr_go       = aw_full_ff & w_full_ff & ~s_axi_bvalid;
    if (wr_go) begin
      nxt_aw_full = 1'b0;
      nxt_w_full  = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      aw_full_ff    <= 1'b0;
      w_full_ff     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= '0;
      wstrb_ff      <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= spmc_pkg::RESP_OKAY;
      ctrl_ff       <= spmc_pkg::CTRL_RST;
    end else begin
      aw_full_ff    <= nxt_aw_full;
      w_full_ff     <= nxt_w_full;
      s_axi_awready <= ~nxt_aw_full;
      s_axi_wready  <= ~nxt_w_full;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= spmc_pkg::RESP_OKAY;
        if (awaddr_ff == spmc_pkg::ADDR_CTRL) begin
          if (wstrb_ff[0]) begin
            ctrl_ff[spmc_pkg::CTRL_TRST:spmc_pkg::CTRL_DED] <=
              wdata_ff[spmc_pkg::CTRL_TRST:spmc_pkg::CTRL_DED];
          end
        end else if (awaddr_ff != spmc_pkg::ADDR_STATUS) begin
          s_axi_bresp <= spmc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    status = '0;
    status[spmc_pkg::ST_OWNED]  = owned_ff;
    status[spmc_pkg::ST_ACTIVE] = scan_act;
    status[spmc_pkg::ST_SEL_LSB +: 2*spmc_pkg::SEL_W] = sel_ff;
    status[spmc_pkg::ST_TAP_LSB +: 16] = tap_ff;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= spmc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= spmc_pkg::RESP_OKAY;
      if (s_axi_araddr == spmc_pkg::ADDR_CTRL) begin
        s_axi_rdata <= ctrl_ff;
      end else if (s_axi_araddr == spmc_pkg::ADDR_STATUS) begin
        s_axi_rdata <= status;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= spmc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      s_axi_rvalid  <= ~s_axi_rready;
      s_axi_arready <= s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n_ff);

  property p_ded_pins;
    ded && $past(ded) |-> !o_pin_oe.tck && !o_pin_oe.tdi && !o_user_in.tck;
  endproperty
  a_ded_pins: assert property (p_ded_pins) else $error("Dedicated pins driven by user"); // [RULE2]
  property p_ded_pu;
    ded && $past(ded) |-> o_pu_tms && o_pu_tdi;
  endproperty
  a_ded_pu: assert property (p_ded_pu) else $error("Pull-ups off in dedicated mode"); // [RULE3]
  property p_flex_pu;
    !ded && $past(ded) == 1'b0 |-> !o_pu_tms && !o_pu_tdi;
  endproperty
  a_flex_pu: assert property (p_flex_pu) else $error("Pull-ups on in flexible mode"); // [RULE4]
  property p_claim;
    claim |=> owned_ff ##1 (o_pin_oe.tck == 1'b0);
  endproperty
  a_claim: assert property (p_claim) else $error("Claim did not take pins"); // [RULE5]
  property p_hold;
    owned_ff && tap_ff != spmc_pkg::S_TLR |=> owned_ff;
  endproperty
  a_hold: assert property (p_hold) else $error("Pins released outside reset state"); // [RULE6]
  property p_five;
    tms_hi_ff >= spmc_pkg::TMS_HI_RST |-> tap_ff == spmc_pkg::S_TLR ##1 !owned_ff;
  endproperty
  a_five: assert property (p_five) else $error("Five TMS-high cycles missed reset"); // [RULE7]
  property p_trst_rsv;
    trst_rsv && $past(trst_rsv) |-> o_pu_trst && !o_pin_oe.trst;
  endproperty
  a_trst_rsv: assert property (p_trst_rsv) else $error("Reserved TRST misconfigured"); // [RULE8]
  property p_trst_user;
    !trst_rsv && !$past(trst_rsv) |-> !o_pu_trst && o_pin_oe.trst == $past(i_user_oe.trst);
  endproperty
  a_trst_user: assert property (p_trst_user) else $error("User TRST misconfigured"); // [RULE9]
  property p_probe;
    !fuse_s && sel_ff.a < NET_CNT |=> o_probe_out_a == $past(i_nets[sel_ff.a]);
  endproperty
  a_probe: assert property (p_probe) else $error("Probe A does not follow net"); // [RULE10]
  property p_fuse;
    fuse_s |=> !o_probe_out_a && !o_probe_out_b;
  endproperty
  a_fuse: assert property (p_fuse) else $error("Probe active with fuse set"); // [RULE11]
  property p_trst_hold;
    tap_rst |=> tap_ff == spmc_pkg::S_TLR;
  endproperty
  a_trst_hold: assert property (p_trst_hold) else $error("TRST did not reset TAP"); // [RULE8]

  c_claim:   cover property (claim ##[1:1000] !owned_ff);
  c_probe:   cover property (tck_rise && tap_ff == spmc_pkg::S_UDR && ir_ff == spmc_pkg::IR_PROBE);
  c_ded:     cover property (ded && tck_rise && tap_ff == spmc_pkg::S_SHDR);
  c_trst:    cover property (tap_rst && tap_ff != spmc_pkg::S_TLR);
endmodule

// file: rtl/spmc_pkg.sv
// Constants, types and register map of the scan pin mode control block.
// Assumes a single system clock; test pins arrive unsynchronised.
// Summary of operation
// RULE1: TMS is always scan control, never user pin
// RULE2: Dedicated mode binds TCK, TDI, TDO to scan
// RULE3: Dedicated mode enables TMS, TDI pull-ups; standard TAP
// RULE4: Flexible mode: pull-ups off, pins are user I/O
// RULE5: TCK rise with TMS low claims pins
// RULE6: Claimed pins return to user at Test-Logic-Reset
// RULE7: Five TCK cycles TMS high reach Test-Logic-Reset
// RULE8: Reserved TRST: async active-low reset, pull-up on
// RULE9: Unreserved TRST: user I/O, pull-up off
// RULE10: Scan port selects nets driven onto probes
// RULE11: Security fuse disables probe outputs entirely
// RULE12: Leave TRST floating while probing
// RULE13: Sixteen-state TAP, reset state at power-up
package spmc_pkg;
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam int          CTRL_DED    = 0;
  localparam int          CTRL_TRST   = 1;
  localparam int          ST_OWNED    = 0;
  localparam int          ST_ACTIVE   = 1;
  localparam int          ST_SEL_LSB  = 8;
  localparam int          ST_TAP_LSB  = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          SEL_W       = 4;
  localparam int          IR_W        = 4;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam logic [3:0]  IR_BYPASS   = 4'hf;
  localparam logic [3:0]  IR_PROBE    = 4'h2;
  localparam logic [2:0]  TMS_HI_RST  = 3'h5;

  typedef struct packed {
    logic trst;
    logic tdo;
    logic tdi;
    logic tck;
  } spmc_pins_t;

  typedef struct packed {
    logic [SEL_W-1:0] b;
    logic [SEL_W-1:0] a;
  } spmc_sel_t;

  typedef enum logic [15:0] {
    S_TLR  = 16'h0001, S_RTI  = 16'h0002, S_SDS  = 16'h0004, S_CDR  = 16'h0008,
    S_SHDR = 16'h0010, S_E1DR = 16'h0020, S_PDR  = 16'h0040, S_E2DR = 16'h0080,
    S_UDR  = 16'h0100, S_SIS  = 16'h0200, S_CIR  = 16'h0400, S_SHIR = 16'h0800,
    S_E1IR = 16'h1000, S_PIR  = 16'h2000, S_E2IR = 16'h4000, S_UIR  = 16'h8000
  } spmc_tap_t;
endpackage

// file: test/spmc_jtag_model.sv
// External JTAG tester model: drives TCK, TMS, TDI and TRST pads, samples TDO.
// Assumes the bench resolves pad levels; TCK stands still low between frames.
module spmc_jtag_model (
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  output logic      o_trst_b
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_tck    = 1'b0;
    o_tms    = 1'b1;
    o_tdi    = 1'b0;
    o_trst_b = 1'b1;  // Driven high so the TAP stays out of reset without the pull-up
  end

  // One 161 ns TCK period; TDO sampled just before the rise, after a full low phase
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    // Step off the system clock edge so a tick started on that edge never moves pads as they are sampled
    #1;
    o_tms = tms;
    o_tdi = tdi;
    #80;
    tdo   = i_tdo;
    o_tck = 1'b1;
    #80;
    o_tck = 1'b0;
  endtask

  // Walk the TAP with a TMS sequence, LSB first
  task automatic move(input logic [7:0] tms, input int n);
    logic b;
    for (int i = 0; i < n; i++) tick(tms[i], 1'b0, b);
  endtask

  // Shift n bits LSB first from a Shift state, then Update and back to Idle
  task automatic shift(input logic [7:0] v, input int n, output logic [7:0] q);
    logic b;
    q = 8'h00;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, v[i], b);
      q[i] = b;
    end
    move(8'h01, 2);
  endtask

  task automatic trst_pulse();
    #1;
    o_trst_b = 1'b0;
    #400;
    o_trst_b = 1'b1;
  endtask
endmodule

// file: test/spmc_tb_top.sv
// Self-checking bench for the scan pin mode control block.
// Assumes an AXI4-Lite master here and the JTAG tester model on the test pads.
module spmc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, fuse, pu_tms, pu_tdi, pu_trst, pa, pb;
  logic        m_tck, m_tms, m_tdi, m_trst_b, tdo_q, d;
  logic [31:0] awaddr, wdata, araddr, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] nets;
  logic [7:0]  q;
  int          mismatches, n_tests;
  spmc_pkg::spmc_pins_t pin_in, pin_out, pin_oe, user_out, user_oe, user_in;

  always #2 clk = ~clk;

  // Released TDO shows the inverse of its last value so a stale bit never passes
  assign pin_in = '{trst: pin_oe.trst ? pin_out.trst : m_trst_b,
                    tdo:  pin_oe.tdo ? pin_out.tdo : ~tdo_q,
                    tdi:  pin_oe.tdi ? pin_out.tdi : m_tdi,
                    tck:  pin_oe.tck ? pin_out.tck : m_tck};
  always @(posedge clk) if (pin_oe.tdo) tdo_q <= pin_out.tdo;

  spmc_top #(.NET_CNT(16)) dut (
    .i_clk_sys(clk), .i_rst_b(rst_b), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .i_tms(m_tms), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .i_user_out(user_out), .i_user_oe(user_oe), .o_user_in(user_in),
    .o_pu_tms(pu_tms), .o_pu_tdi(pu_tdi), .o_pu_trst(pu_trst), .i_sec_fuse(fuse),
    .i_nets(nets), .o_probe_out_a(pa), .o_probe_out_b(pb));

  spmc_jtag_model m (.i_tdo(pin_in.tdo), .o_tck(m_tck), .o_tms(m_tms), .o_tdi(m_tdi),
                     .o_trst_b(m_trst_b));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report();
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task tmo();
    chk(32'h0, 32'h1);
    final_report();
  endtask

  task wr(input logic [31:0] a, input logic [31:0] dat);
    int   n;
    logic aw, w;
    aw = 1'b0;
    w  = 1'b0;
    n  = 0;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= dat;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
      n++;
      if (n > 100) tmo();
    end while (!(aw && w));
    while (bvalid !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 200) tmo();
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 100) tmo();
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 200) tmo();
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task t_regs();
    rd(spmc_pkg::ADDR_CTRL);
    chk(v, spmc_pkg::CTRL_RST);
    rd(spmc_pkg::ADDR_STATUS);
    chk(v & 32'h0001_0003, 32'h0001_0000);
    chk({29'h0, pu_tms, pu_tdi, pu_trst}, 32'h0);
    wr(32'h0000_0010, 32'h0000_0003);
    chk({30'h0, r}, {30'h0, spmc_pkg::RESP_SLVERR});
    rd(32'h0000_0010);
    chk(v, 32'h0);
    chk({30'h0, r}, {30'h0, spmc_pkg::RESP_SLVERR});
    wr(spmc_pkg::ADDR_STATUS, 32'hffff_ffff);
    chk({30'h0, r}, {30'h0, spmc_pkg::RESP_OKAY});
    rd(spmc_pkg::ADDR_CTRL);
    chk(v, spmc_pkg::CTRL_RST);
    $display("test regs done");
  endtask

  task t_flex();
    user_oe  <= 4'h4;
    user_out <= 4'h4;
    repeat (4) @(posedge clk);
    chk({28'h0, pin_oe}, 32'h4);
    chk({31'h0, pin_out.tdo}, 32'h1);
    chk({31'h0, user_in.trst}, 32'h1);
    m.tick(1'b0, 1'b0, d);
    @(posedge clk);
    chk({30'h0, pin_oe[1:0]}, 32'h0);
    chk({30'h0, user_in[1:0]}, 32'h0);
    m.move(8'h01, 3);
    rd(spmc_pkg::ADDR_STATUS);
    chk(v & 32'hffff_0001, 32'h0010_0001);
    // Four rises with TMS high from Shift-DR must not yet release the pins
    m.move(8'h0f, 4);
    rd(spmc_pkg::ADDR_STATUS);
    chk({31'h0, v[0]}, 32'h1);
    m.move(8'h01, 1);
    rd(spmc_pkg::ADDR_STATUS);
    chk(v & 32'h0001_0001, 32'h0001_0000);
    chk({28'h0, pin_oe}, 32'h4);
    $display("test flex done");
  endtask

  task t_probe();
    user_oe  <= 4'hf;
    user_out <= 4'hf;
    wr(spmc_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk({30'h0, pu_tms, pu_tdi}, 32'h3);
    chk({29'h0, pin_oe[2:0]}, 32'h0);
    m.move(8'h06, 5);
    m.shift({4'h0, spmc_pkg::IR_PROBE}, 4, q);
    chk({28'h0, q[3:0]}, {28'h0, spmc_pkg::IR_CAPTURE});
    m.move(8'h01, 3);
    m.shift(8'ha3, 8, q);
    rd(spmc_pkg::ADDR_STATUS);
    chk({24'h0, v[15:8]}, 32'ha3);
    nets <= 16'h0408;
    repeat (3) @(posedge clk);
    chk({30'h0, pa, pb}, 32'h3);
    nets <= 16'hfbf7;
    repeat (3) @(posedge clk);
    chk({30'h0, pa, pb}, 32'h0);
    nets <= 16'h0408;
    fuse <= 1'b1;
    repeat (6) @(posedge clk);
    chk({30'h0, pa, pb}, 32'h0);
    $display("test probe done");
  endtask

  task t_trst();
    wr(spmc_pkg::ADDR_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    chk({30'h0, pu_trst, pin_oe.trst}, 32'h2);
    m.trst_pulse();
    repeat (4) @(posedge clk);
    rd(spmc_pkg::ADDR_STATUS);
    chk(v & 32'h0001_ff00, 32'h0001_0000);
    wr(spmc_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk({29'h0, pu_tms, pu_tdi, pu_trst}, 32'h0);
    chk({31'h0, pin_oe.trst}, 32'h1);
    $display("test trst done");
  endtask

  initial begin
    clk        = 1'b0;
    rst_b      = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, fuse} = 6'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb      = 4'hf;
    nets       = 16'h0000;
    user_out   = 4'h0;
    user_oe    = 4'h0;
    tdo_q      = 1'b0;
    mismatches = 0;
    n_tests    = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_flex();
    t_probe();
    t_trst();
    final_report();
  end
endmodule
